// ==== logic/afd_fifo_dma_status.sv ====
/*
 * fifo status, dma request status and dma channel mapping registers.
 * assumes the fifos live on the link clock and present raw flags there,
 * and that the dma controller answers on clk_i with one-cycle acks.
 */
`timescale 1ns/10ps

module afd_fifo_dma_status
   import afd_pkg::*;
(
   input  wire logic            clk_i,
   input  wire logic            rst_n_i,
   input  wire logic            link_clk_i,
   input  wire afd_fifo_flags_t link_flags_i,
   input  wire logic [7:0]      dma_ack_i,
   input  wire afd_bus_req_t    bus_i,
   output logic [31:0]          rd_data_o,
   output logic [7:0]           dma_req_o
);

   // ************************************************************
   // mapping decode
   // ************************************************************
   function automatic logic [7:0] map_allow(input logic [1:0] sel);
      case (sel)
         2'h0:    map_allow = MAP0_MASK;
         2'h1:    map_allow = MAP1_MASK;
         2'h2:    map_allow = MAP2_MASK;
         default: map_allow = MAP3_MASK;
      endcase
   endfunction

   function automatic logic [7:0] sample_clear(input afd_bus_req_t req);
      logic [7:0] clr;
      clr = CH_RST;
      if (req.wr) begin
         if (req.addr == REG_PCM_OUT)  clr[CH_PCM]  = 1'b1;
         if (req.addr == REG_SURR_OUT) clr[CH_SURR] = 1'b1;
         if (req.addr == REG_CENT_OUT) clr[CH_CENT] = 1'b1;
         if (req.addr == REG_LFE_OUT)  clr[CH_LFE]  = 1'b1;
         if (req.addr == REG_MOD_OUT)  clr[CH_MODO] = 1'b1;
      end
      if (req.rd) begin
         if (req.addr == REG_AUD_IN)   clr[CH_AUDIN] = 1'b1;
         if (req.addr == REG_MOD_IN)   clr[CH_MODI]  = 1'b1;
      end
      sample_clear = clr;
   endfunction

   // ************************************************************
   // link domain: reset bring-in and flag capture
   // ************************************************************
   logic            link_rst_s1;
   logic            link_rst_n;
   afd_fifo_flags_t link_flags;
   afd_fifo_flags_t next_link_flags;

   always_comb begin
      next_link_flags.tx_full = link_flags_i.tx_full & TX_CH_MASK;
      next_link_flags.fill    = link_flags_i.fill & CH_MASK;
   end

   // reset arrives from the system domain, so it is synchronised first
   always_ff @(posedge link_clk_i) begin
      link_rst_s1 <= rst_n_i;
      link_rst_n  <= link_rst_s1;
      if (!link_rst_n) begin
         link_flags <= '0;
      end else begin
         link_flags <= next_link_flags;
      end
   end

   // ************************************************************
   // crossing into clk_i: independent levels, two flops each
   // ************************************************************
   // bits may land one cycle apart; each flag is meaningful on its own
   afd_fifo_flags_t flags_s1;
   afd_fifo_flags_t flags_sync;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         flags_s1   <= '0;
         flags_sync <= '0;
      end else begin
         flags_s1   <= link_flags;
         flags_sync <= flags_s1;
      end
   end

   // ************************************************************
   // dma pending flags and mapping
   // ************************************************************
   logic [1:0] dma_map;
   logic       dma_en;
   logic [7:0] pending;
   logic [7:0] next_pending;
   logic [1:0] next_dma_map;
   logic       next_dma_en;
   logic [7:0] want;
   logic [7:0] set_vec;
   logic [7:0] clr_vec;
   logic [7:0] allow;

   always_comb begin
      allow = map_allow(dma_map);
      // tx channels ask for data while not full, rx while holding data
      want = (TX_CH_MASK & ~flags_sync.tx_full) |
             (RX_CH_MASK & flags_sync.fill);
      set_vec = want & allow & {8{dma_en}};
      clr_vec = sample_clear(bus_i) | dma_ack_i;
      // set wins over a clear in the same cycle
      next_pending = ((pending & ~clr_vec) | set_vec) & CH_MASK;
      next_dma_map = dma_map;
      next_dma_en  = dma_en;
      // remap is not interlocked against pending requests
      if (bus_i.wr && bus_i.addr == REG_DMA_MAP) begin
         next_dma_map = bus_i.wdata[MAP_W-1:0];
      end
      if (bus_i.wr && bus_i.addr == REG_DMA_CTRL) begin
         next_dma_en = bus_i.wdata[0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         pending <= CH_RST;
         dma_map <= MAP_RST;
         dma_en  <= DMA_EN_RST;
      end else begin
         pending <= next_pending;
         dma_map <= next_dma_map;
         dma_en  <= next_dma_en;
      end
   end

   // ************************************************************
   // register read port
   // ************************************************************
   logic [31:0] next_rd_data;
   logic [31:0] rd_data;

   always_comb begin
      next_rd_data = RD_DATA_RST;
      if (bus_i.rd) begin
         case (bus_i.addr)
            REG_FIFO_STS: begin
               next_rd_data[FULL_POS +: 8] = flags_sync.tx_full
                                             & TX_CH_MASK;
               next_rd_data[7:0] = flags_sync.fill & CH_MASK;
            end
            REG_DMA_STS: begin
               next_rd_data[7:0] = pending;
            end
            REG_DMA_MAP: begin
               next_rd_data[MAP_W-1:0] = dma_map;
            end
            REG_DMA_CTRL: begin
               next_rd_data[0] = dma_en;
            end
            // reserved bits and unmapped addresses stay zero
            default: next_rd_data = RD_DATA_RST;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         rd_data <= RD_DATA_RST;
      end else begin
         rd_data <= next_rd_data;
      end
   end

   assign rd_data_o = rd_data;
   assign dma_req_o = pending;

   // ************************************************************
   // checks
   // ************************************************************
   map_write_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (bus_i.wr && bus_i.addr == REG_DMA_MAP)
      |=> dma_map == $past(bus_i.wdata[1:0]))
      else $error("mapping field did not take the written value");

   map_read_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (bus_i.rd && bus_i.addr == REG_DMA_MAP)
      |=> rd_data_o == {30'h0000_0000, $past(dma_map)})
      else $error("mapping read shows wrong value or reserved bits");

   fifo_rsv_zero_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (bus_i.rd && bus_i.addr == REG_FIFO_STS)
      |=> rd_data_o[31:15] == 17'h0_0000 && rd_data_o[13:12] == 2'h0
          && rd_data_o[5] == 1'b0)
      else $error("fifo status reserved bits not zero");

   full_report_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (bus_i.rd && bus_i.addr == REG_FIFO_STS)
      |=> rd_data_o[14:8] == $past(flags_sync.tx_full[6:0] & 7'h4f))
      else $error("full flags misreported");

   fill_report_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (bus_i.rd && bus_i.addr == REG_FIFO_STS)
      |=> rd_data_o[7:0] == $past(flags_sync.fill & 8'hdf))
      else $error("fill flags misreported");

   rx_fill_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (bus_i.rd && bus_i.addr == REG_FIFO_STS && flags_sync.fill[7]
       && flags_sync.fill[4])
      |=> rd_data_o[7] && rd_data_o[4])
      else $error("receive non-empty flags not shown");

   dma_sts_read_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (bus_i.rd && bus_i.addr == REG_DMA_STS)
      |=> rd_data_o == {24'h00_0000, $past(dma_req_o)})
      else $error("dma status read differs from pending flags");

   out_clear_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (bus_i.wr && bus_i.addr == REG_PCM_OUT && !set_vec[CH_PCM])
      |=> !dma_req_o[CH_PCM])
      else $error("pcm out write did not clear its request");

   in_clear_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (bus_i.rd && bus_i.addr == REG_AUD_IN && !set_vec[CH_AUDIN])
      |=> !dma_req_o[CH_AUDIN])
      else $error("audio in read did not clear its request");

   stale_hold_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (dma_req_o[CH_MODO] && !dma_en && !clr_vec[CH_MODO])
      |=> dma_req_o[CH_MODO])
      else $error("stale request dropped without a clearing access");

   map_gate_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      $rose(dma_req_o[CH_SURR]) |-> $past(allow[CH_SURR] && dma_en))
      else $error("request raised on an unmapped channel");

   clear_cov: cover property (
      @(posedge clk_i) disable iff (!rst_n_i)
      dma_req_o[CH_PCM] && !dma_en ##1
      (bus_i.wr && bus_i.addr == REG_PCM_OUT) ##1 !dma_req_o[CH_PCM]);

   remap_cov: cover property (
      @(posedge clk_i) disable iff (!rst_n_i)
      dma_map == 2'h0 ##[1:20] dma_map == 2'h2);

   full_cov: cover property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (bus_i.rd && bus_i.addr == REG_FIFO_STS) ##1 rd_data_o[14]);

   ack_cov: cover property (
      @(posedge clk_i) disable iff (!rst_n_i)
      dma_ack_i[CH_CENT] ##1 !dma_req_o[CH_CENT]);

   rx_req_cov: cover property (
      @(posedge clk_i) disable iff (!rst_n_i)
      dma_req_o[CH_MODI] && dma_map == 2'h0);

   // ************************************************************
   // checks on request timing and idle read data
   // ************************************************************
   // a stale read value would be taken by a later read; keep it zero
   rd_idle_zero_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      !bus_i.rd |=> rd_data_o == RD_DATA_RST)
      else $error("read data not zero outside a read answer");

   sts_rsv_zero_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (bus_i.rd && bus_i.addr == REG_DMA_STS)
      |=> rd_data_o[31:8] == 24'h00_0000 && !rd_data_o[5])
      else $error("dma status reserved bits not zero");

   // set beats any clear, so a live condition always shows next cycle
   tx_set_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (dma_en && allow[CH_PCM] && !flags_sync.tx_full[CH_PCM])
      |=> dma_req_o[CH_PCM])
      else $error("pcm out request not raised while room is free");

   rx_set_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (dma_en && allow[CH_MODI] && flags_sync.fill[CH_MODI])
      |=> dma_req_o[CH_MODI])
      else $error("modem in request not raised while data waits");

   ack_clear_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (dma_ack_i[CH_CENT] && !set_vec[CH_CENT])
      |=> !dma_req_o[CH_CENT])
      else $error("center request survived its acknowledge");

   modem_rd_clear_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (bus_i.rd && bus_i.addr == REG_MOD_IN && !set_vec[CH_MODI])
      |=> !dma_req_o[CH_MODI])
      else $error("modem in read did not clear its request");

   modem_wr_clear_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (bus_i.wr && bus_i.addr == REG_MOD_OUT && !set_vec[CH_MODO])
      |=> !dma_req_o[CH_MODO])
      else $error("modem out write did not clear its request");

   surr_wr_clear_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (bus_i.wr && bus_i.addr == REG_SURR_OUT && !set_vec[CH_SURR])
      |=> !dma_req_o[CH_SURR])
      else $error("surround write did not clear its request");

   lfe_wr_clear_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (bus_i.wr && bus_i.addr == REG_LFE_OUT && !set_vec[CH_LFE])
      |=> !dma_req_o[CH_LFE])
      else $error("lfe write did not clear its request");

   // a disabled block may hold old requests but must raise no new one
   idle_no_set_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (!dma_en && !dma_req_o[CH_LFE]) |=> !dma_req_o[CH_LFE])
      else $error("lfe request raised while dma is disabled");

   full_gate_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      $rose(dma_req_o[CH_PCM]) |-> $past(!flags_sync.tx_full[CH_PCM]))
      else $error("pcm out request raised on a full fifo");

   map_hold_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      !(bus_i.wr && bus_i.addr == REG_DMA_MAP) |=> $stable(dma_map))
      else $error("mapping changed without a write to it");

endmodule

// ==== logic/afd_pkg.sv ====
/*
 * shared constants and carriers for the slot fifo and dma status block.
 * assumes a 16-bit byte address on the register port and a link clock
 * domain that supplies raw fifo flags.
 */
package afd_pkg;

   // ************************************************************
   // register offsets (byte addresses)
   // ************************************************************
   localparam logic [15:0] REG_FIFO_STS  = 16'hf750;
   localparam logic [15:0] REG_DMA_STS   = 16'hf780;
   localparam logic [15:0] REG_DMA_MAP   = 16'hf784;
   localparam logic [15:0] REG_DMA_CTRL  = 16'hf788;
   localparam logic [15:0] REG_PCM_OUT   = 16'hf7a0;
   localparam logic [15:0] REG_SURR_OUT  = 16'hf7a4;
   localparam logic [15:0] REG_CENT_OUT  = 16'hf7a8;
   localparam logic [15:0] REG_LFE_OUT   = 16'hf7ac;
   localparam logic [15:0] REG_AUD_IN    = 16'hf7b0;
   localparam logic [15:0] REG_MOD_OUT   = 16'hf7b8;
   localparam logic [15:0] REG_MOD_IN    = 16'hf7bc;

   // ************************************************************
   // channel bit positions and field layout
   // ************************************************************
   localparam int CH_PCM   = 0;
   localparam int CH_SURR  = 1;
   localparam int CH_CENT  = 2;
   localparam int CH_LFE   = 3;
   localparam int CH_AUDIN = 4;
   localparam int CH_MODO  = 6;
   localparam int CH_MODI  = 7;
   localparam int FULL_POS = 8;
   localparam int MAP_W    = 2;

   localparam logic [7:0] TX_CH_MASK = 8'h4f;
   localparam logic [7:0] RX_CH_MASK = 8'h90;
   localparam logic [7:0] CH_MASK    = 8'hdf;

   // channels that own a dma channel for each mapping value
   localparam logic [7:0] MAP0_MASK = 8'hd1;
   localparam logic [7:0] MAP1_MASK = 8'hc3;
   localparam logic [7:0] MAP2_MASK = 8'h0f;
   localparam logic [7:0] MAP3_MASK = 8'h17;

   // ************************************************************
   // reset values
   // ************************************************************
   localparam logic [1:0]  MAP_RST     = 2'h0;
   localparam logic        DMA_EN_RST  = 1'b0;
   localparam logic [7:0]  CH_RST      = 8'h00;
   localparam logic [31:0] RD_DATA_RST = 32'h0000_0000;

   // ************************************************************
   // carriers
   // ************************************************************
   typedef struct packed {
      logic [7:0] tx_full;
      logic [7:0] fill;
   } afd_fifo_flags_t;

   typedef struct packed {
      logic [15:0] addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } afd_bus_req_t;

endpackage

// ==== test/afd_far_model.sv ====
/*
 * far-side model: link fifo flags on the link clock, dma controller acks.
 * assumes the bench sets the flag pattern and when acks are allowed.
 */
`timescale 1ns/10ps
module afd_far_model
   import afd_pkg::*;
(
   input  wire logic            clk_i,
   input  wire logic            rst_n_i,
   input  wire logic            link_clk_i,
   input  wire afd_fifo_flags_t want_i,
   input  wire logic            ack_en_i,
   input  wire logic [7:0]      dma_req_i,
   output afd_fifo_flags_t      link_flags_o,
   output logic [7:0]           dma_ack_o
);
   // flags move only on link edges, never in step with clk_i
   always @(posedge link_clk_i)
      link_flags_o <= want_i;
   // one-cycle acks; a quiet cycle between pulses, like a busy dmac
   always @(posedge clk_i)
      dma_ack_o <= (rst_n_i && ack_en_i) ? dma_req_i & ~dma_ack_o : 8'h00;
endmodule

// ==== test/tb_afd_fifo_dma_status.sv ====
/*
 * self-checking bench for the fifo and dma status registers.
 * assumes the far model on the link clock and the package offsets.
 */
`timescale 1ns/10ps
module tb_afd_fifo_dma_status;
   import afd_pkg::*;
   logic            clk = 1'b0;
   logic            link_clk = 1'b0;
   logic            rst_n = 1'b0;
   logic            ack_en = 1'b0;
   afd_bus_req_t    bus = '0;
   afd_fifo_flags_t want = '0;
   afd_fifo_flags_t f;
   afd_fifo_flags_t link_flags;
   logic [7:0]      dma_ack;
   logic [7:0]      dma_req;
   logic [7:0]      exp_req;
   logic [31:0]     rd_data;
   logic [31:0]     rdv;
   logic [15:0]     seed = 16'h0018;
   int              fail_count = 0;
   int              cmp_count = 0;
   localparam logic [15:0] SMP [8] = '{REG_PCM_OUT, REG_SURR_OUT,
      REG_CENT_OUT, REG_LFE_OUT, REG_AUD_IN, 16'h0000, REG_MOD_OUT,
      REG_MOD_IN};
   localparam logic [7:0] MAPS [4] = '{8'hd1, 8'hc3, 8'h0f, 8'h17};
   localparam logic [15:0] ZADDR [6] = '{REG_FIFO_STS, REG_DMA_STS,
      REG_DMA_MAP, REG_AUD_IN, REG_MOD_IN, 16'hf7f0};

   always #2 clk = ~clk;
   always #62.5 link_clk = ~link_clk;

   afd_fifo_dma_status afd_fifo_dma_status_i (.clk_i(clk), .rst_n_i(rst_n),
      .link_clk_i(link_clk), .link_flags_i(link_flags), .dma_ack_i(dma_ack),
      .bus_i(bus), .rd_data_o(rd_data), .dma_req_o(dma_req));
   afd_far_model afd_far_model_i (.clk_i(clk), .rst_n_i(rst_n),
      .link_clk_i(link_clk), .want_i(want), .ack_en_i(ack_en),
      .dma_req_i(dma_req), .link_flags_o(link_flags), .dma_ack_o(dma_ack));

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [31:0] exp_fifo(input afd_fifo_flags_t x);
      return (32'(x.tx_full & 8'h4f) << 8) | 32'(x.fill & 8'hdf);
   endfunction

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic bus_wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge clk);
      bus.addr <= a;
      bus.wdata <= d;
      bus.wr <= 1'b1;
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask
   task automatic bus_rd(input logic [15:0] a);
      @(posedge clk);
      bus.addr <= a;
      bus.rd <= 1'b1;
      @(posedge clk);
      bus.rd <= 1'b0;
      #1 rdv = rd_data;
   endtask
   // bounded poll: flags cross two clock domains with loose latency
   task automatic poll(input string what, input logic [15:0] a,
                       input logic [31:0] exp);
      for (int n = 0; n < 300; n++) begin
         bus_rd(a);
         if (rdv === exp)
            break;
      end
      check(what, rdv, exp);
      // a poll that ran out of tries ends the run with what was counted
      if (rdv !== exp)
         tally_and_finish();
   endtask
   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial begin
      // reset must span link edges too, else the link side stays unknown
      repeat (3) @(posedge link_clk);
      @(posedge clk);
      rst_n <= 1'b1;
      bus_wr(REG_DMA_STS, 32'hffff_ffff);
      bus_wr(REG_FIFO_STS, 32'hffff_ffff);
      for (int k = 0; k < 6; k++) begin
         bus_rd(ZADDR[k]);
         check("zero read", rdv, 32'h0000_0000);
      end
      $display("test reset done");
      for (int m = 0; m < 4; m++) begin
         bus_wr(REG_DMA_MAP, 32'hffff_fffc | 32'(m));
         bus_rd(REG_DMA_MAP);
         check("map field", rdv, 32'(m));
         @(posedge clk);
         #1 check("read idle", rd_data, 32'h0000_0000);
      end
      $display("test map field done");
      for (int i = 0; i < 6; i++) begin
         seed = lfsr(seed);
         f = (i == 4) ? 16'hffff : (i == 5) ? 16'h0000 : seed;
         want <= f;
         exp_req = MAPS[i % 4] & ((~f.tx_full & 8'h4f) | (f.fill & 8'h90));
         poll("fifo status", REG_FIFO_STS, exp_fifo(f));
         // nothing pending here, so remapping is safe
         bus_wr(REG_DMA_MAP, 32'(i % 4));
         bus_wr(REG_DMA_CTRL, 32'h0000_0001);
         poll("dma status", REG_DMA_STS, 32'(exp_req));
         check("req lines", 32'(dma_req), 32'(exp_req));
         bus_wr(REG_DMA_CTRL, 32'h0000_0000);
         if (i == 3)
            ack_en <= 1'b1;
         else
            for (int c = 0; c < 8; c++) begin
               if (c == 5)
                  continue;
               if (c == 4 || c == 7)
                  bus_rd(SMP[c]);
               else begin
                  bus_wr(SMP[c], {seed, seed});
                  #1;
               end
               check("req cleared", 32'(dma_req[c]), 32'h0000_0000);
            end
         poll("stale req", REG_DMA_STS, 32'h0000_0000);
         ack_en <= 1'b0;
         $display("test dma pass %0d done", i);
      end
      tally_and_finish();
   end
endmodule
